/* File: pkg/field_policy_pkg.sv */
// field access policy constants shared by the policy block
// assumes one register word per access, bus in the mclk domain
package field_policy_pkg;

    // ======================================================
    // field policy codes, one per field
    typedef enum logic [3:0] {
        POL_READ_WRITE       = 4'h0,
        POL_ZERO_WRITES_DROP = 4'h1,
        POL_ONE_KEEP         = 4'h2,
        POL_ZERO_KEEP        = 4'h3,
        POL_W1C              = 4'h4,
        POL_READ_ONLY        = 4'h5,
        POL_WRITE_ONLY       = 4'h6,
        POL_UNSPEC_ZERO_KEEP = 4'h7,
        POL_UNSPEC_ONE_KEEP  = 4'h8
    } field_policy_t;

    // ======================================================
    // widths and reset values
    localparam int          DATA_W      = 32;
    localparam int          BIT_POL_W   = 4;
    localparam logic [31:0] STORE_RESET = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : field_policy_pkg

/* File: rtl/register_field_access_policy.sv */
// one register word with a policy per bit: read value and write effect
// assumes a single-cycle request strobe and hardware status inputs on mclk
`timescale 1ns/1ps

module register_field_access_policy #(
    parameter int           WIDTH  = 32,
    parameter logic [127:0] POLICY = 128'h0
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // access request
    input  wire logic             req,
    input  wire logic             wr,
    input  wire logic [WIDTH-1:0] wdata,
    // answer
    output logic                  ack,
    output logic      [WIDTH-1:0] rdata,
    // hardware side
    input  wire logic [WIDTH-1:0] hw_set,
    input  wire logic [WIDTH-1:0] hw_value,
    output logic      [WIDTH-1:0] stored
);

    // ======================================================
    // per-bit policy decode
    function automatic logic [3:0] pol_of(input int i);
        pol_of = POLICY[i*4 +: 4];
    endfunction : pol_of

    logic [WIDTH-1:0] is_rw;
    logic [WIDTH-1:0] is_one;
    logic [WIDTH-1:0] is_w1c;
    logic [WIDTH-1:0] is_ro;
    logic [WIDTH-1:0] is_wo;
    logic [WIDTH-1:0] is_zd;
    logic [WIDTH-1:0] is_zk;
    logic [WIDTH-1:0] is_ok;
    logic [WIDTH-1:0] is_uz;
    logic [WIDTH-1:0] is_uo;
    logic [WIDTH-1:0] store;

    for (genvar g = 0; g < WIDTH; g++) begin : g_dec
        assign is_rw[g]  = pol_of(g) == field_policy_pkg::POL_READ_WRITE;
        assign is_one[g] = pol_of(g) == field_policy_pkg::POL_ONE_KEEP
                        || pol_of(g) == field_policy_pkg::POL_UNSPEC_ONE_KEEP;
        assign is_w1c[g] = pol_of(g) == field_policy_pkg::POL_W1C;
        assign is_ro[g]  = pol_of(g) == field_policy_pkg::POL_READ_ONLY;
        assign is_wo[g]  = pol_of(g) == field_policy_pkg::POL_WRITE_ONLY;
        // constant-field decode for the checks
        assign is_zd[g]  = pol_of(g) == field_policy_pkg::POL_ZERO_WRITES_DROP;
        assign is_zk[g]  = pol_of(g) == field_policy_pkg::POL_ZERO_KEEP;
        assign is_ok[g]  = pol_of(g) == field_policy_pkg::POL_ONE_KEEP;
        assign is_uz[g]  = pol_of(g) == field_policy_pkg::POL_UNSPEC_ZERO_KEEP;
        assign is_uo[g]  = pol_of(g) == field_policy_pkg::POL_UNSPEC_ONE_KEEP;
    end

    // ======================================================
    // write path
    wire              do_wr    = req && wr;
    wire [WIDTH-1:0]  wr_mask  = is_rw | is_wo;
    wire [WIDTH-1:0]  clr_mask = is_w1c & wdata & {WIDTH{do_wr}};
    wire [WIDTH-1:0]  w1c_next = (store & ~clr_mask) | hw_set;
    wire [WIDTH-1:0]  ro_next  = hw_value;
    wire [WIDTH-1:0]  wr_next  = do_wr ? ((store & ~wr_mask) | (wdata & wr_mask)) : store;
    wire [WIDTH-1:0]  next_store = (wr_next & wr_mask) | (w1c_next & is_w1c)
                                 | (ro_next & is_ro);

    // ======================================================
    // read path
    // unspecified and write-only read constants
    wire [WIDTH-1:0]  rd_val = (store & (is_rw | is_w1c | is_ro)) | is_one;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            store <= field_policy_pkg::STORE_RESET[WIDTH-1:0];
            stored <= field_policy_pkg::STORE_RESET[WIDTH-1:0];
            rdata <= field_policy_pkg::RDATA_RESET[WIDTH-1:0];
            ack   <= 1'b0;
        end else begin
            store  <= next_store;
            stored <= next_store;
            ack   <= req;
            rdata <= (req && !wr) ? rd_val : field_policy_pkg::RDATA_RESET[WIDTH-1:0];
        end
    end

    // ======================================================
    // checks
    // answer next cycle
    property p_ack_one_cycle;
        @(posedge mclk) disable iff (sys_rst) req |=> ack;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("no ack after req");

    property p_ack_needs_req;
        @(posedge mclk) disable iff (sys_rst) !req |=> !ack;
    endproperty
    a_ack_needs_req: assert property (p_ack_needs_req)
        else $error("ack without req");

    property p_one_reads;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((rdata & is_one) == is_one);
    endproperty
    a_one_reads: assert property (p_one_reads)
        else $error("one field read not one");

    property p_const_zero;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((rdata & ~(is_rw | is_w1c | is_ro | is_one)) == '0);
    endproperty
    a_const_zero: assert property (p_const_zero)
        else $error("constant field not zero");

    property p_zero_drop_write;
        @(posedge mclk) disable iff (sys_rst)
            do_wr |=> ((store & is_zd) == '0);
    endproperty
    a_zero_drop_write: assert property (p_zero_drop_write)
        else $error("dropped field took a write");

    property p_zero_keep_read;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((rdata & is_zk) == '0);
    endproperty
    a_zero_keep_read: assert property (p_zero_keep_read)
        else $error("zero-keep field read not zero");

    property p_keep_write_ignored;
        @(posedge mclk) disable iff (sys_rst)
            do_wr |=> ((store & (is_zk | is_ok | is_uz | is_uo)) == '0);
    endproperty
    a_keep_write_ignored: assert property (p_keep_write_ignored)
        else $error("keep field took a write");

    property p_w1c_clear;
        @(posedge mclk) disable iff (sys_rst)
            do_wr |=> ((store & is_w1c & $past(wdata) & ~$past(hw_set)) == '0);
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("w1c bit not cleared");

    property p_w1c_keep;
        @(posedge mclk) disable iff (sys_rst)
            1'h1 |=> ((($past(store) | $past(hw_set)) & is_w1c & ~$past(clr_mask))
                      == (store & is_w1c & ~$past(clr_mask)));
    endproperty
    a_w1c_keep: assert property (p_w1c_keep)
        else $error("w1c bit lost");

    property p_ro_follows;
        @(posedge mclk) disable iff (sys_rst)
            1'h1 |=> ((store & is_ro) == ($past(hw_value) & is_ro));
    endproperty
    a_ro_follows: assert property (p_ro_follows)
        else $error("read-only bit wrong");

    property p_rw_write;
        @(posedge mclk) disable iff (sys_rst)
            do_wr |=> ((store & wr_mask) == ($past(wdata) & wr_mask));
    endproperty
    a_rw_write: assert property (p_rw_write)
        else $error("writable bit not written");

    property p_read_keeps;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((store & wr_mask) == ($past(store) & wr_mask));
    endproperty
    a_read_keeps: assert property (p_read_keeps)
        else $error("read disturbed store");

    property p_unspec_zero_read;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((rdata & is_uz) == '0);
    endproperty
    a_unspec_zero_read: assert property (p_unspec_zero_read)
        else $error("unspecified zero field read not zero");

    property p_unspec_one_read;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((rdata & is_uo) == is_uo);
    endproperty
    a_unspec_one_read: assert property (p_unspec_one_read)
        else $error("unspecified one field read not one");

    property p_one_keep_read;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((rdata & is_ok) == is_ok);
    endproperty
    a_one_keep_read: assert property (p_one_keep_read)
        else $error("one-keep field read not one");

    property p_wo_hidden;
        @(posedge mclk) disable iff (sys_rst)
            (req && !wr) |=> ((rdata & is_wo) == '0);
    endproperty
    a_wo_hidden: assert property (p_wo_hidden)
        else $error("write-only bit exposed");

    property p_write_rdata_zero;
        @(posedge mclk) disable iff (sys_rst)
            do_wr |=> (rdata == '0);
    endproperty
    a_write_rdata_zero: assert property (p_write_rdata_zero)
        else $error("read data on a write answer");

endmodule : register_field_access_policy

/* File: tb/access_master.sv */
// bus master model: one-cycle requests, keeps field write policies
// assumes bench commands change just after the mclk rising edge
`timescale 1ns/1ps
module access_master #(
    parameter int          W  = 32,
    parameter logic [31:0] ZK = '0,
    parameter logic [31:0] OK = '0
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // bench commands
    input  wire logic         go,
    input  wire logic         want_wr,
    input  wire logic [W-1:0] data,
    // bus
    output logic              req,
    output logic              wr,
    output logic [W-1:0]      wdata,
    input  wire logic         ack,
    input  wire logic [W-1:0] rdata
);
    logic [W-1:0] last_rd;
    logic         rd_pend;
    // keep fields get reset or read value
    always @(posedge mclk) begin
        if (sys_rst) last_rd <= OK;
        else if (ack && rd_pend) last_rd <= rdata & (ZK | OK);
        rd_pend <= req && !wr && !sys_rst;
        req   <= #1 go && !sys_rst;
        wr    <= #1 want_wr;
        wdata <= #1 (data & ~(ZK | OK)) | (last_rd & (ZK | OK));
    end
endmodule : access_master

/* File: tb/testbench.sv */
// self-checking bench: random and corner accesses against a policy model
// assumes policy code of bit i is i mod 9
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
    localparam int W = 32;
    function automatic logic [127:0] mkpol();
        for (int i = 0; i < W; i++) mkpol[4*i +: 4] = 4'(i % 9);
    endfunction : mkpol
    function automatic logic [W-1:0] msk(input logic [8:0] c);
        for (int i = 0; i < W; i++) msk[i] = c[i % 9];
    endfunction : msk
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    localparam logic [W-1:0] MR = msk(9'h031), MO = msk(9'h104), MW = msk(9'h041);
    localparam logic [W-1:0] MC = msk(9'h010), MRO = msk(9'h020);
    logic         mclk = 0, sys_rst = 1, go = 0, want_wr = 0, req, wr, ack, e_ack;
    logic [W-1:0] data = '0, hw_set = '0, hw_value = '0, wdata, rdata, stored, e_st, e_rd;
    logic [31:0]  seed = 32'h8;
    int           errors = 0, compares = 0, cyc = 0;
    access_master #(.W(W), .ZK(msk(9'h088)), .OK(MO)) access_master_i (.mclk(mclk),
        .sys_rst(sys_rst), .go(go), .want_wr(want_wr), .data(data), .req(req), .wr(wr),
        .wdata(wdata), .ack(ack), .rdata(rdata));
    register_field_access_policy #(.WIDTH(W), .POLICY(mkpol())) register_field_access_policy_i (
        .mclk(mclk), .sys_rst(sys_rst), .req(req), .wr(wr), .wdata(wdata), .ack(ack),
        .rdata(rdata), .hw_set(hw_set), .hw_value(hw_value), .stored(stored));
    // ==========================================
    // expected behaviour per field policy
    always @(posedge mclk) begin
        if (sys_rst) begin
            e_st <= '0;
            e_ack <= 0;
            e_rd <= '0;
        end else begin
            e_ack <= req;
            e_rd <= (req && !wr) ? (e_st & MR) | MO : '0;
            e_st <= (hw_value & MRO) | (MC & (hw_set | (e_st & ~(req && wr ? wdata : '0))))
                | (MW & (req && wr ? wdata : e_st));
        end
    end
    always @(negedge mclk) begin
        if (!sys_rst) begin
            `CHK("stored_w1c", e_st & MC, stored & MC)
            `CHK("stored_ro", e_st & MRO, stored & MRO)
            `CHK("stored", e_st, stored)
            `CHK("rdata_one", e_rd & MO, rdata & MO)
            `CHK("rdata", e_rd, rdata)
            `CHK("ack", e_ack, ack)
        end
    end
    task automatic drive(input logic g, w, input logic [W-1:0] d, hs);
        @(posedge mclk);
        #1;
        go = g;
        want_wr = w;
        data = d;
        hw_set = hs;
        seed = xs(seed);
        hw_value = seed;
    endtask : drive
    task end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 5000) begin errors++; end_of_test(); end
    initial begin
        repeat (12) @(posedge mclk);
        #1 sys_rst = 0;
        // ones written, set wins, read back, zeros written
        drive(1'h1, 1'h1, '1, '0);
        drive(1'h1, 1'h1, '1, '1);
        drive(1'h1, 1'h0, '0, '0);
        drive(1'h1, 1'h1, '0, '0);
        drive(1'h1, 1'h0, '0, '0);
        drive(1'h0, 1'h0, '0, '0);
        $display("test corner done");
        repeat (2000) begin
            seed = xs(seed);
            drive(seed[0], seed[1], xs(seed), xs(seed ^ 32'h5a) & seed & xs(seed + 1));
        end
        drive(1'h0, 1'h0, '0, '0);
        drive(1'h0, 1'h0, '0, '0);
        $display("test random done");
        // mid-run reset clears answer and store
        sys_rst = 1'h1;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("rst_ack", 1'h0, ack)
        `CHK("rst_rdata", 32'h0, rdata)
        `CHK("rst_stored", 32'h0, stored)
        sys_rst = 1'h0;
        repeat (4) @(posedge mclk);
        $display("test reset done");
        end_of_test();
    end
endmodule : testbench
